// >>> logic/sima_pkg.sv
// Purpose: constants and types for the serial unit interrupt mask block
// Assumes: one clock, AXI4-Lite register access, 32-bit data
// Notes:   six event sources, one bit each, same order in every register
//
// Notes on behaviour
// R1 - one mask bit per source, bits 5:0
// R2 - write one to enable-set sets mask bit
// R3 - write one to enable-clear clears mask bit
// R4 - set and clear registers are write-only
// R5 - mask state reads current mask, one passes
// R6 - mask state read-only, changed only by set/clear
// R7 - all mask bits zero after reset
// R8 - bits 31:6 read zero, ignored on write
// R9 - raw state directly after mask state, same order
// R10 - raw bit follows event condition regardless of mask
// R11 - pending shows unmasked events, write one clears
// R12 - zero writes no effect; line ORs pending bits
// R13 - clear beats set on same bit
package sima_pkg;
   localparam int          SIMA_NSRC       = 6;
   localparam int          SIMA_AW         = 8;
   localparam logic [7:0]  SIMA_OFS_ENSET  = 8'h2C;
   localparam logic [7:0]  SIMA_OFS_ENCLR  = 8'h30;
   localparam logic [7:0]  SIMA_OFS_MASK   = 8'h34;
   localparam logic [7:0]  SIMA_OFS_RAW    = 8'h38;
   localparam logic [7:0]  SIMA_OFS_PEND   = 8'h3C;
   localparam int          SIMA_BIT_CONT   = 5;
   localparam int          SIMA_BIT_RXFULL = 4;
   localparam int          SIMA_BIT_RXOVF  = 3;
   localparam int          SIMA_BIT_RXUNF  = 2;
   localparam int          SIMA_BIT_TXOVF  = 1;
   localparam int          SIMA_BIT_TXEMP  = 0;
   localparam logic [5:0]  SIMA_MASK_RST   = 6'h00;
   localparam logic [1:0]  SIMA_RESP_OKAY  = 2'h0;
   localparam logic [1:0]  SIMA_RESP_SLVERR = 2'h2;

   typedef struct packed {
      logic       contention;
      logic       rx_full;
      logic       rx_overflow;
      logic       rx_underflow;
      logic       tx_overflow;
      logic       tx_empty;
   } sima_src_t;

   typedef struct packed {
      logic [7:0]  awaddr;
      logic        awvalid;
      logic [31:0] wdata;
      logic [3:0]  wstrb;
      logic        wvalid;
      logic        bready;
      logic [7:0]  araddr;
      logic        arvalid;
      logic        rready;
   } sima_axi_req_t;

   typedef struct packed {
      logic        awready;
      logic        wready;
      logic [1:0]  bresp;
      logic        bvalid;
      logic        arready;
      logic [31:0] rdata;
      logic [1:0]  rresp;
      logic        rvalid;
   } sima_axi_rsp_t;
endpackage

// >>> logic/sima_bit.sv
// Purpose: one source lane: mask bit and pending bit
// Assumes: strobes are single-cycle, same clock
// Notes:   clear wins over set on the mask; event set wins over w1c
`timescale 1ns/10ps
module sima_bit (
   input  wire logic mclk,
   input  wire logic reset_n,
   input  wire logic set_en,
   input  wire logic clr_en,
   input  wire logic raw,
   input  wire logic pend_clr,
   output logic      mask_q,
   output logic      pend_q
);
   typedef struct packed {
      logic mask;
      logic pend;
   } sima_bit_state_t;

   sima_bit_state_t state_reg;
   sima_bit_state_t state_next;

   always_comb begin
      state_next = state_reg;
      if (clr_en) begin                                   // [R3] [R13]
         state_next.mask = 1'b0;
      end else if (set_en) begin                          // [R2]
         state_next.mask = 1'b1;
      end
      if (raw && state_reg.mask) begin                    // [R11]
         state_next.pend = 1'b1;
      end else if (pend_clr) begin
         state_next.pend = 1'b0;
      end
   end

   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         state_reg <= '0;                                 // [R7]
      end else begin
         state_reg <= state_next;
      end
   end

   assign mask_q = state_reg.mask;
   assign pend_q = state_reg.pend;

   property p_clr_wins;
      @(posedge mclk) disable iff (!reset_n)
      clr_en |=> !mask_q;
   endproperty
   a_clr_wins: assert property (p_clr_wins) else $error("mask not cleared"); // [R13]

   property p_set;
      @(posedge mclk) disable iff (!reset_n)
      set_en && !clr_en |=> mask_q;
   endproperty
   a_set: assert property (p_set) else $error("mask not set"); // [R2]

   property p_pend_cause;
      @(posedge mclk) disable iff (!reset_n)
      $rose(pend_q) |-> $past(raw) && $past(mask_q);
   endproperty
   a_pend_cause: assert property (p_pend_cause) else $error("pending without cause"); // [R11]

   property p_mask_hold;
      @(posedge mclk) disable iff (!reset_n)
      !set_en && !clr_en |=> $stable(mask_q);
   endproperty
   a_mask_hold: assert property (p_mask_hold) else $error("mask changed alone"); // [R6]
endmodule // sima_bit

// >>> logic/sima_top.sv
// Purpose: interrupt mask, raw and pending registers of the serial unit
// Assumes: AXI4-Lite master keeps at most one write and one read open
// Notes:   raw inputs are same-clock levels from the serial engine
//
// The AXI4-Lite register port was left to the implementer.
`timescale 1ns/10ps
module sima_top #(
   parameter int NSRC = 6
) (
   input  wire logic                    mclk,
   input  wire logic                    reset_n,
   input  wire sima_pkg::sima_axi_req_t axi_req,
   output sima_pkg::sima_axi_rsp_t      axi_rsp,
   input  wire sima_pkg::sima_src_t     src_event,
   output logic                         irq
);
   import sima_pkg::*;

   if (NSRC != SIMA_NSRC) begin : g_chk
      $error("NSRC must equal six");
   end

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   typedef struct packed {
      logic              aw_got;
      logic [7:0]        awaddr;
      logic              w_got;
      logic [31:0]       wdata;
      logic [3:0]        wstrb;
      logic              bvalid;
      logic [1:0]        bresp;
      logic              rvalid;
      logic [31:0]       rdata;
      logic [1:0]        rresp;
   } sima_state_t;

   sima_state_t       state_reg;
   sima_state_t       state_next;
   logic [NSRC-1:0]   raw_vec;
   logic [NSRC-1:0]   mask_vec;
   logic [NSRC-1:0]   pend_vec;
   logic [NSRC-1:0]   set_vec;
   logic [NSRC-1:0]   clr_vec;
   logic [NSRC-1:0]   pclr_vec;
   logic              wr_fire;
   logic              aw_take;
   logic              w_take;
   logic              ar_take;
   logic [7:0]        ar_addr;

   assign raw_vec = src_event;                               // [R1] [R10]
   assign ar_addr = {axi_req.araddr[7:2], 2'b00};

   // ------------------------------------------------------------
   // per-source lanes
   // ------------------------------------------------------------
   for (genvar i = 0; i < NSRC; i++) begin : g_lane
      sima_bit u_bit (
         .mclk     (mclk),
         .reset_n  (reset_n),
         .set_en   (set_vec[i]),
         .clr_en   (clr_vec[i]),
         .raw      (raw_vec[i]),
         .pend_clr (pclr_vec[i]),
         .mask_q   (mask_vec[i]),
         .pend_q   (pend_vec[i])
      );
   end

   // ------------------------------------------------------------
   // AXI4-Lite slave
   // ------------------------------------------------------------
   assign aw_take = axi_req.awvalid && !state_reg.aw_got && !state_reg.bvalid;
   assign w_take  = axi_req.wvalid && !state_reg.w_got && !state_reg.bvalid;
   assign ar_take = axi_req.arvalid && !state_reg.rvalid;
   assign wr_fire = state_reg.aw_got && state_reg.w_got && !state_reg.bvalid;

   // only the low byte holds live bits; zero writes do nothing
   always_comb begin
      set_vec  = '0;
      clr_vec  = '0;
      pclr_vec = '0;
      if (wr_fire && state_reg.wstrb[0]) begin
         unique case (state_reg.awaddr)
            SIMA_OFS_ENSET: set_vec  = state_reg.wdata[NSRC-1:0]; // [R2] [R8] [R12]
            SIMA_OFS_ENCLR: clr_vec  = state_reg.wdata[NSRC-1:0]; // [R3] [R8] [R12]
            SIMA_OFS_PEND:  pclr_vec = state_reg.wdata[NSRC-1:0]; // [R11]
            default: ;
         endcase
      end
   end

   always_comb begin
      state_next = state_reg;
      if (aw_take) begin
         state_next.aw_got = 1'b1;
         state_next.awaddr = {axi_req.awaddr[7:2], 2'b00};
      end
      if (w_take) begin
         state_next.w_got = 1'b1;
         state_next.wdata = axi_req.wdata;
         state_next.wstrb = axi_req.wstrb;
      end
      if (wr_fire) begin
         state_next.aw_got = 1'b0;
         state_next.w_got  = 1'b0;
         state_next.bvalid = 1'b1;
         unique case (state_reg.awaddr)
            SIMA_OFS_ENSET, SIMA_OFS_ENCLR, SIMA_OFS_PEND:
               state_next.bresp = SIMA_RESP_OKAY;
            // mask and raw are read-only: write refused
            default: state_next.bresp = SIMA_RESP_SLVERR;   // [R6]
         endcase
      end
      if (state_reg.bvalid && axi_req.bready) begin
         state_next.bvalid = 1'b0;
      end
      if (ar_take) begin
         state_next.rvalid = 1'b1;
         state_next.rresp  = SIMA_RESP_OKAY;
         state_next.rdata  = '0;
         unique case ({axi_req.araddr[7:2], 2'b00})
            SIMA_OFS_ENSET, SIMA_OFS_ENCLR: state_next.rdata = '0; // [R4]
            SIMA_OFS_MASK: state_next.rdata[NSRC-1:0] = mask_vec;  // [R5] [R8]
            SIMA_OFS_RAW:  state_next.rdata[NSRC-1:0] = raw_vec;   // [R9] [R10]
            SIMA_OFS_PEND: state_next.rdata[NSRC-1:0] = pend_vec;  // [R11]
            default:       state_next.rresp = SIMA_RESP_SLVERR;
         endcase
      end else if (state_reg.rvalid && axi_req.rready) begin
         state_next.rvalid = 1'b0;
      end
   end

   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         state_reg <= '0;
      end else begin
         state_reg <= state_next;
      end
   end

   assign axi_rsp.awready = !state_reg.aw_got && !state_reg.bvalid;
   assign axi_rsp.wready  = !state_reg.w_got && !state_reg.bvalid;
   assign axi_rsp.bvalid  = state_reg.bvalid;
   assign axi_rsp.bresp   = state_reg.bresp;
   assign axi_rsp.arready = !state_reg.rvalid;
   assign axi_rsp.rvalid  = state_reg.rvalid;
   assign axi_rsp.rdata   = state_reg.rdata;
   assign axi_rsp.rresp   = state_reg.rresp;

   assign irq = |pend_vec;                                   // [R12]

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   property p_reset_mask;
      @(posedge mclk) !$past(reset_n) |-> mask_vec == SIMA_MASK_RST;
   endproperty
   a_reset_mask: assert property (p_reset_mask) else $error("mask not zero after reset"); // [R7]

   property p_irq_or;
      @(posedge mclk) disable iff (!reset_n)
      ((raw_vec & mask_vec) != '0) |=> irq;
   endproperty
   a_irq_or: assert property (p_irq_or) else $error("unmasked event gave no irq"); // [R12]

   property p_pend_masked;
      @(posedge mclk) disable iff (!reset_n)
      (mask_vec == '0) && (pend_vec == '0) |=> pend_vec == '0;
   endproperty
   a_pend_masked: assert property (p_pend_masked) else $error("masked source pended"); // [R11]

   property p_mask_read;
      @(posedge mclk) disable iff (!reset_n)
      ar_take && ({axi_req.araddr[7:2], 2'b00} == SIMA_OFS_MASK)
         |=> rdata_ok(state_reg.rdata, $past(mask_vec));
   endproperty
   a_mask_read: assert property (p_mask_read) else $error("mask read wrong"); // [R5] [R8]

   property p_raw_read;
      @(posedge mclk) disable iff (!reset_n)
      ar_take && ({axi_req.araddr[7:2], 2'b00} == SIMA_OFS_RAW)
         |=> rdata_ok(state_reg.rdata, $past(raw_vec));
   endproperty
   a_raw_read: assert property (p_raw_read) else $error("raw read wrong"); // [R9] [R10]

   property p_wo_read;
      @(posedge mclk) disable iff (!reset_n)
      ar_take && (({axi_req.araddr[7:2], 2'b00} == SIMA_OFS_ENSET)
         || ({axi_req.araddr[7:2], 2'b00} == SIMA_OFS_ENCLR)) |=> state_reg.rdata == '0;
   endproperty
   a_wo_read: assert property (p_wo_read) else $error("write-only read nonzero"); // [R4]

   property p_zero_write;
      @(posedge mclk) disable iff (!reset_n)
      wr_fire && (state_reg.wdata[NSRC-1:0] == '0) |=> $stable(mask_vec);
   endproperty
   a_zero_write: assert property (p_zero_write) else $error("zero write moved mask"); // [R12]

   property p_resp_time;
      @(posedge mclk) disable iff (!reset_n)
      wr_fire |=> state_reg.bvalid;
   endproperty
   a_resp_time: assert property (p_resp_time) else $error("no write response"); // [R2]

   // ------------------------------------------------------------
   // bus and lane checks
   // ------------------------------------------------------------
   property p_b_hold;
      @(posedge mclk) disable iff (!reset_n)
      axi_rsp.bvalid && !axi_req.bready |=> axi_rsp.bvalid && $stable(axi_rsp.bresp);
   endproperty
   a_b_hold: assert property (p_b_hold) else $error("write response dropped early"); // [R2]

   property p_r_hold;
      @(posedge mclk) disable iff (!reset_n)
      axi_rsp.rvalid && !axi_req.rready
         |=> axi_rsp.rvalid && $stable(axi_rsp.rdata) && $stable(axi_rsp.rresp);
   endproperty
   a_r_hold: assert property (p_r_hold) else $error("read data dropped early"); // [R5]

   property p_aw_block;
      @(posedge mclk) disable iff (!reset_n)
      axi_rsp.bvalid |-> !axi_rsp.awready;
   endproperty
   a_aw_block: assert property (p_aw_block) else $error("address ready during response"); // [R2]

   property p_w_block;
      @(posedge mclk) disable iff (!reset_n)
      axi_rsp.bvalid |-> !axi_rsp.wready;
   endproperty
   a_w_block: assert property (p_w_block) else $error("data ready during response"); // [R2]

   property p_ar_block;
      @(posedge mclk) disable iff (!reset_n)
      axi_rsp.rvalid |-> !axi_rsp.arready;
   endproperty
   a_ar_block: assert property (p_ar_block) else $error("read ready during read data"); // [R5]

   property p_b_rise;
      @(posedge mclk) disable iff (!reset_n)
      $rose(axi_rsp.bvalid) |-> $past(wr_fire);
   endproperty
   a_b_rise: assert property (p_b_rise) else $error("response without write"); // [R2]

   property p_r_rise;
      @(posedge mclk) disable iff (!reset_n)
      $rose(axi_rsp.rvalid) |-> $past(ar_take);
   endproperty
   a_r_rise: assert property (p_r_rise) else $error("read data without request"); // [R5]

   property p_ro_write;
      @(posedge mclk) disable iff (!reset_n)
      wr_fire && ((state_reg.awaddr == SIMA_OFS_MASK) || (state_reg.awaddr == SIMA_OFS_RAW))
         |=> (state_reg.bresp == SIMA_RESP_SLVERR) && $stable(mask_vec);
   endproperty
   a_ro_write: assert property (p_ro_write) else $error("read-only write accepted"); // [R6]

   property p_unmapped_read;
      @(posedge mclk) disable iff (!reset_n)
      ar_take && (ar_addr != SIMA_OFS_ENSET) && (ar_addr != SIMA_OFS_ENCLR)
         && (ar_addr != SIMA_OFS_MASK) && (ar_addr != SIMA_OFS_RAW)
         && (ar_addr != SIMA_OFS_PEND)
         |=> (state_reg.rresp == SIMA_RESP_SLVERR) && (state_reg.rdata == '0);
   endproperty
   a_unmapped_read: assert property (p_unmapped_read) else $error("unmapped read wrong"); // [R8]

   property p_pend_read;
      @(posedge mclk) disable iff (!reset_n)
      ar_take && (ar_addr == SIMA_OFS_PEND) |=> rdata_ok(state_reg.rdata, $past(pend_vec));
   endproperty
   a_pend_read: assert property (p_pend_read) else $error("pending read wrong"); // [R11]

   property p_pend_clear;
      @(posedge mclk) disable iff (!reset_n)
      pclr_vec != '0
         |=> (pend_vec & $past(pclr_vec) & ~($past(raw_vec) & $past(mask_vec))) == '0;
   endproperty
   a_pend_clear: assert property (p_pend_clear) else $error("pending not cleared"); // [R11]

   property p_set_mask;
      @(posedge mclk) disable iff (!reset_n)
      set_vec != '0
         |=> (mask_vec & $past(set_vec) & ~$past(clr_vec)) == ($past(set_vec) & ~$past(clr_vec));
   endproperty
   a_set_mask: assert property (p_set_mask) else $error("mask bits not set"); // [R2] [R13]

   property p_clr_mask;
      @(posedge mclk) disable iff (!reset_n)
      clr_vec != '0 |=> (mask_vec & $past(clr_vec)) == '0;
   endproperty
   a_clr_mask: assert property (p_clr_mask) else $error("mask bits not cleared"); // [R3] [R13]

   property p_rsvd_zero;
      @(posedge mclk) disable iff (!reset_n)
      axi_rsp.rvalid |-> axi_rsp.rdata[31:NSRC] == '0;
   endproperty
   a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved read bits set"); // [R8]

   property p_irq_reset;
      @(posedge mclk) !$past(reset_n) |-> !irq;
   endproperty
   a_irq_reset: assert property (p_irq_reset) else $error("irq high after reset"); // [R7]

   c_set:  cover property (@(posedge mclk) disable iff (!reset_n) set_vec != '0);
   c_clr:  cover property (@(posedge mclk) disable iff (!reset_n) clr_vec != '0);
   c_irq:  cover property (@(posedge mclk) disable iff (!reset_n) $rose(irq));
   c_both: cover property (@(posedge mclk) disable iff (!reset_n) (set_vec & clr_vec) != '0);

   function automatic logic rdata_ok(logic [31:0] d, logic [NSRC-1:0] v);
      return d == {{(32-NSRC){1'b0}}, v};
   endfunction
endmodule // sima_top

// >>> dv/tb_spi_interrupt_mask_control.sv
// Purpose: self-checking bench for the serial unit interrupt mask block
// Assumes: one AXI4-Lite access open at a time, bench drives every port
// Notes:   mask model is a plain vector updated per completed set or clear write in the mask update test, zeroed on reset
`timescale 1ns/10ps
module tb_spi_interrupt_mask_control;
   import sima_pkg::*;
   logic          mclk;
   logic          reset_n;
   sima_axi_req_t req;
   sima_axi_rsp_t rsp;
   sima_src_t     ev;
   logic          irq;
   int            failures;
   int            check_count;
   int            b;
   logic [31:0]   rd;
   logic [1:0]    rs;
   logic [5:0]    mdl;
   logic [31:0]   w;

   sima_top #(.NSRC(SIMA_NSRC)) uut (.mclk(mclk), .reset_n(reset_n), .axi_req(req),
      .axi_rsp(rsp), .src_event(ev), .irq(irq));

   initial begin
      mclk = 1'b0;
      forever #2.5 mclk = ~mclk;
   end

   // ----------------------------------------
   // bus tasks, handshakes judged at the negedge before each rising edge
   // ----------------------------------------
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      int   n;
      logic ah, wh, bh;
      @(posedge mclk);
      req.awaddr <= a;
      req.wdata <= d;
      req.wstrb <= 4'hF;
      req.awvalid <= 1'b1;
      req.wvalid <= 1'b1;
      req.bready <= 1'b1;
      for (n = 0; n < 40; n++) begin
         @(negedge mclk);
         ah = req.awvalid & rsp.awready;
         wh = req.wvalid & rsp.wready;
         bh = rsp.bvalid;
         rs = rsp.bresp;
         @(posedge mclk);
         if (ah) req.awvalid <= 1'b0;
         if (wh) req.wvalid <= 1'b0;
         if (bh) begin
            req.bready <= 1'b0;
            break;
         end
      end
      if (n == 40) failures++;
   endtask

   task automatic rdt(input logic [7:0] a);
      int   n;
      logic ah, rh;
      @(posedge mclk);
      req.araddr <= a;
      req.arvalid <= 1'b1;
      req.rready <= 1'b1;
      for (n = 0; n < 40; n++) begin
         @(negedge mclk);
         ah = req.arvalid & rsp.arready;
         rh = rsp.rvalid;
         rd = rsp.rdata;
         rs = rsp.rresp;
         @(posedge mclk);
         if (ah) req.arvalid <= 1'b0;
         if (rh) begin
            req.rready <= 1'b0;
            break;
         end
      end
      if (n == 40) failures++;
   endtask

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      check_count++;
      if (g !== e) begin
         failures++;
         $display("unexpected %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic conclude;
      $display("checks %0d mismatches %0d", check_count, failures);
      if (failures == 0 && check_count > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   initial begin
      #400000;
      failures++;
      conclude();
   end

   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      req = '0;
      ev = '0;
      reset_n = 1'b0;
      failures = 0;
      check_count = 0;
      mdl = 6'h00;
      void'($urandom(32'h1378));
      repeat (12) @(posedge mclk);
      reset_n <= 1'b1;
      rdt(SIMA_OFS_MASK);
      chk("mask", 32'h0, rd);
      chk("irq", 32'h0, {31'h0, irq});
      $display("test reset done");
      repeat (24) begin
         w = $urandom;
         ev <= sima_src_t'(w[13:8]);
         wr(SIMA_OFS_ENSET, {26'h0, w[5:0]});
         chk("set_resp", {30'h0, SIMA_RESP_OKAY}, {30'h0, rs});
         mdl = mdl | w[5:0];
         w = $urandom;
         wr(SIMA_OFS_ENCLR, {26'h0, w[5:0]});
         chk("clr_resp", {30'h0, SIMA_RESP_OKAY}, {30'h0, rs});
         mdl = mdl & ~w[5:0];
         wr(SIMA_OFS_ENSET, 32'hFFFF_FFC0);
         rdt(SIMA_OFS_MASK);
         chk("mask", {26'h0, mdl}, rd);
         rdt(SIMA_OFS_RAW);
         chk("raw", {26'h0, ev}, rd);
         rdt(SIMA_OFS_ENSET);
         chk("set_read", 32'h0, rd);
      end
      $display("test mask updates done");
      reset_n <= 1'b0;
      repeat (2) @(posedge mclk);
      reset_n <= 1'b1;
      mdl = 6'h00;
      rdt(SIMA_OFS_MASK);
      chk("mask_rerst", 32'h0, rd);
      chk("irq_rerst", 32'h0, {31'h0, irq});
      $display("test mid-run reset done");
      wr(SIMA_OFS_MASK, 32'h3F);
      chk("ro_resp", {30'h0, SIMA_RESP_SLVERR}, {30'h0, rs});
      rdt(SIMA_OFS_MASK);
      chk("mask", {26'h0, mdl}, rd);
      rdt(8'h40);
      chk("unmapped", 32'h0, rd);
      chk("unmapped_resp", {30'h0, SIMA_RESP_SLVERR}, {30'h0, rs});
      $display("test read-only done");
      ev <= '0;
      wr(SIMA_OFS_ENCLR, 32'h3F);
      wr(SIMA_OFS_PEND, 32'h3F);
      for (b = 0; b < 6; b++) begin
         ev <= sima_src_t'(6'h01 << b);
         repeat (3) @(posedge mclk);
         @(negedge mclk);
         chk("irq_masked", 32'h0, {31'h0, irq});
         @(posedge mclk);
         ev <= '0;
         wr(SIMA_OFS_ENSET, 32'h1 << b);
         ev <= sima_src_t'(6'h01 << b);
         repeat (3) @(posedge mclk);
         ev <= '0;
         repeat (2) @(posedge mclk);
         @(negedge mclk);
         chk("irq_on", 32'h1, {31'h0, irq});
         rdt(SIMA_OFS_PEND);
         chk("pending", 32'h1 << b, rd);
         wr(SIMA_OFS_PEND, 32'h1 << b);
         rdt(SIMA_OFS_PEND);
         chk("pending_clr", 32'h0, rd);
         @(negedge mclk);
         chk("irq_off", 32'h0, {31'h0, irq});
         wr(SIMA_OFS_ENCLR, 32'h1 << b);
      end
      $display("test event lanes done");
      conclude();
   end
endmodule // tb_spi_interrupt_mask_control
